// ===== include/sci_pkg.sv
package serial_pkg;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_TXDATA = 8'h0c;
    localparam logic [7:0] OFS_RXDATA = 8'h10;

    // Control register fields
    localparam int CTRL_W = 6;
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_SYNC = 2;
    localparam int CTRL_EXT_CLK = 3;
    localparam int CTRL_PAR_EN = 4;
    localparam int CTRL_PAR_ODD = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // Status register fields
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_RX_FULL = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_FRAMING = 3;
    localparam int ST_PARITY = 4;
    localparam int ST_TX_END = 5;

    localparam int DIV_W = 16;
    localparam logic [15:0] BAUD_RST = 16'h0000;

    // Bit timing on the sixteen-times base clock
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_TICK = 4'h7;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [3:0] FRAME_BITS_PAR = 4'hb;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [3:0] SYNC_LAST_IDX = 4'h7;
    localparam logic [3:0] STOP_IDX = 4'h9;
    localparam logic [3:0] STOP_IDX_PAR = 4'ha;
    localparam logic [3:0] PAR_IDX = 4'h9;

    // Delay from last clocked bit to receive completion, system clocks
    localparam logic [1:0] EXT_DONE_DLY = 2'h3;
    localparam logic [1:0] INT_DONE_DLY = 2'h2;

    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_PEND} rx_state_t;

endpackage

// ===== include/bit_timing_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bit_timing_if #(parameter int DIV_W = 16);
    logic [DIV_W-1:0] divisor;
    logic tick;
    modport gen (input divisor, output tick);
    modport user (output divisor, input tick);
endinterface
`default_nettype wire

// ===== src/baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
module baud_gen #(parameter int DIV_W = 16) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Base clock
    bit_timing_if.gen bt
);
    logic [DIV_W-1:0] cnt_r;
    logic tick_r;

    // One tick every divisor+1 clocks
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r >= bt.divisor) begin
            cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    assign bt.tick = tick_r;

endmodule
`default_nettype wire

// ===== src/serial_comm_unit.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module serial_comm_unit (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire logic [serial_pkg::ADDR_W-1:0] addr,
    input wire logic [serial_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic dma_sel,
    output logic [serial_pkg::DATA_W-1:0] rd_data,
    // Requests
    output logic tx_empty_irq,
    output logic rx_full_irq,
    output logic rx_error_irq,
    // Serial pins
    input wire logic rxd_in,
    output logic txd_out,
    output logic txd_oe,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // Port fallback for the transmit pin
    input wire logic port_data_bit,
    input wire logic pin_function_ctrl
);
    import serial_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    logic [CTRL_W-1:0] ctrl_r;
    logic [DIV_W-1:0] baud_r;
    logic [7:0] tx_data_r, rx_data_r;
    logic tx_empty_r, rx_full_r, ovr_r, fer_r, per_r, tx_end_r;
    logic [DATA_W-1:0] rd_data_r, rd_nxt;
    logic tx_en, rx_en, sync, ext, par_en, par_odd, err_any;
    logic wr_ctrl, wr_baud, wr_st, wr_txd, dma_rxd_rd;
    logic rxd_s1, rxd_s2, rxd_d_r, sck_s1, sck_s2, sck_d_r;
    logic rxd_fall, sck_rise, sck_fall, tick;
    logic sck_int_r, int_run, int_rise, int_fall, bit_rise, bit_fall, rx_only_run;
    tx_state_t tx_state_r;
    logic [10:0] tx_shift_r;
    logic [3:0] tx_bits_r, tx_cnt_r;
    logic tx_first_r, tx_load, tx_bit_end;
    rx_state_t rx_state_r;
    logic [3:0] rx_cnt_r, rx_idx_r, stop_idx;
    logic [7:0] rx_shift_r;
    logic rx_par_r, brk_r, rx_sample;
    logic [1:0] rx_dly_r;
    logic async_done, sync_done, rx_done, nocopy, done_fe, done_pe;
    logic txd_out_r, txd_oe_r, sck_oe_r;

    bit_timing_if #(.DIV_W(DIV_W)) bt ();
    assign bt.divisor = baud_r;
    assign tick = bt.tick;

    baud_gen #(.DIV_W(DIV_W)) u_baud (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .bt(bt)
    );

    assign tx_en = ctrl_r[CTRL_TX_EN];
    assign rx_en = ctrl_r[CTRL_RX_EN];
    assign sync = ctrl_r[CTRL_SYNC];
    assign ext = ctrl_r[CTRL_EXT_CLK];
    assign par_en = ctrl_r[CTRL_PAR_EN];
    assign par_odd = ctrl_r[CTRL_PAR_ODD];
    assign err_any = ovr_r | fer_r | per_r;

    assign wr_ctrl = wr_en && hit(addr, OFS_CTRL);
    assign wr_baud = wr_en && hit(addr, OFS_BAUD);
    assign wr_st = wr_en && hit(addr, OFS_STATUS);
    assign wr_txd = wr_en && hit(addr, OFS_TXDATA);
    assign dma_rxd_rd = rd_en && dma_sel && hit(addr, OFS_RXDATA);

    // Pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rxd_s1 <= 1'b1;
            rxd_s2 <= 1'b1;
            rxd_d_r <= 1'b1;
            sck_s1 <= 1'b1;
            sck_s2 <= 1'b1;
            sck_d_r <= 1'b1;
        end else begin
            rxd_s1 <= rxd_in;
            rxd_s2 <= rxd_s1;
            rxd_d_r <= rxd_s2;
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_d_r <= sck_s2;
        end
    end

    assign rxd_fall = rxd_d_r & ~rxd_s2;
    assign sck_rise = sck_s2 & ~sck_d_r;
    assign sck_fall = sck_d_r & ~sck_s2;

    // Internal serial clock, idles high
    assign rx_only_run = rx_en & ~tx_en & ~err_any & (rx_state_r != RX_PEND);
    assign int_run = sync & ~ext & ((tx_state_r == TX_SHIFT) | rx_only_run);
    always_ff @(posedge sys_clk) begin
        if (!rstn || !sync || ext) begin
            sck_int_r <= 1'b1;
        end else if (tick && (int_run || !sck_int_r)) begin
            sck_int_r <= ~sck_int_r;
        end
    end
    assign int_rise = tick & ~sck_int_r;
    assign int_fall = tick & sck_int_r & int_run;
    assign bit_rise = ext ? sck_rise : int_rise;
    assign bit_fall = ext ? sck_fall : int_fall;

    // Register writes
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
            baud_r <= BAUD_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= wr_data[CTRL_W-1:0];
            end
            if (wr_baud) begin
                baud_r <= wr_data[DIV_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tx_data_r <= 8'h00;
        end else if (wr_txd) begin
            tx_data_r <= wr_data[7:0];
        end
    end

    assign tx_load = tx_en & (tx_state_r == TX_IDLE) & ~tx_empty_r & ~wr_txd & ~(sync & err_any);
    assign tx_bit_end = (tx_state_r == TX_SHIFT) && (tx_bits_r == 4'h1) &&
        (sync ? bit_rise : (tick && tx_cnt_r == OVERSAMPLE_LAST));

    always_ff @(posedge sys_clk) begin
        if (!rstn || !tx_en) begin
            tx_state_r <= TX_IDLE;
            tx_shift_r <= '1;
            tx_bits_r <= 4'h0;
            tx_cnt_r <= 4'h0;
            tx_first_r <= 1'b1;
        end else begin
            unique case (tx_state_r)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_state_r <= TX_SHIFT;
                        tx_cnt_r <= 4'h0;
                        tx_first_r <= 1'b1;
                        if (sync) begin
                            tx_shift_r <= {3'h7, tx_data_r};
                            tx_bits_r <= SYNC_BITS;
                        end else if (par_en) begin
                            tx_shift_r <= {1'b1, (^tx_data_r) ^ par_odd, tx_data_r, 1'b0};
                            tx_bits_r <= FRAME_BITS_PAR;
                        end else begin
                            tx_shift_r <= {2'h3, tx_data_r, 1'b0};
                            tx_bits_r <= FRAME_BITS;
                        end
                    end
                end
                TX_SHIFT: begin
                    if (!sync) begin
                        if (tick) begin
                            tx_cnt_r <= tx_cnt_r + 4'h1;
                            if (tx_cnt_r == OVERSAMPLE_LAST) begin
                                tx_shift_r <= {1'b1, tx_shift_r[10:1]};
                                tx_bits_r <= tx_bits_r - 4'h1;
                            end
                        end
                    end else begin
                        if (bit_fall && !tx_first_r) begin
                            tx_shift_r <= {1'b1, tx_shift_r[10:1]};
                        end
                        if (bit_rise) begin
                            tx_first_r <= 1'b0;
                            tx_bits_r <= tx_bits_r - 4'h1;
                        end
                    end
                    if (tx_bit_end) begin
                        tx_state_r <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receiver
    assign stop_idx = par_en ? STOP_IDX_PAR : STOP_IDX;
    assign rx_sample = (rx_state_r == RX_FRAME) && !sync && tick && (rx_cnt_r == SAMPLE_TICK);
    assign async_done = rx_sample && (rx_idx_r == stop_idx);
    assign sync_done = (rx_state_r == RX_PEND) && (rx_dly_r == 2'h1);
    assign nocopy = sync_done & ~rx_en;
    assign rx_done = async_done | sync_done;
    // Low stop bit is framing error
    assign done_fe = async_done & ~rxd_s2;
    assign done_pe = async_done & par_en & ((^{rx_shift_r, rx_par_r}) != par_odd);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r <= 4'h0;
            rx_idx_r <= 4'h0;
            rx_shift_r <= 8'h00;
            rx_par_r <= 1'b0;
            rx_dly_r <= 2'h0;
            brk_r <= 1'b0;
        end else begin
            if (rxd_s2) begin
                brk_r <= 1'b0;
            end
            unique case (rx_state_r)
                RX_IDLE: begin
                    // Start edge, or line still low after a break
                    if (rx_en && !sync && !rxd_s2 && (rxd_fall || brk_r)) begin
                        rx_state_r <= RX_FRAME;
                        rx_cnt_r <= 4'h0;
                        rx_idx_r <= 4'h0;
                    end else if (rx_en && sync && bit_rise) begin
                        rx_state_r <= RX_FRAME;
                        rx_shift_r <= {rxd_s2, rx_shift_r[7:1]};
                        rx_idx_r <= 4'h1;
                    end
                end
                RX_FRAME: begin
                    if (!rx_en) begin
                        rx_state_r <= RX_IDLE;
                    end else if (!sync) begin
                        if (tick) begin
                            rx_cnt_r <= rx_cnt_r + 4'h1;
                        end
                        if (rx_sample) begin
                            rx_idx_r <= rx_idx_r + 4'h1;
                            if (rx_idx_r == 4'h0 && rxd_s2) begin
                                rx_state_r <= RX_IDLE;
                            end else if (rx_idx_r >= 4'h1 && rx_idx_r <= SYNC_BITS) begin
                                rx_shift_r <= {rxd_s2, rx_shift_r[7:1]};
                            end else if (par_en && rx_idx_r == PAR_IDX) begin
                                rx_par_r <= rxd_s2;
                            end
                            if (async_done) begin
                                rx_state_r <= RX_IDLE;
                                brk_r <= ~rxd_s2;
                            end
                        end
                    end else if (bit_rise) begin
                        rx_shift_r <= {rxd_s2, rx_shift_r[7:1]};
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_idx_r == SYNC_LAST_IDX) begin
                            rx_state_r <= RX_PEND;
                            rx_dly_r <= ext ? EXT_DONE_DLY : INT_DONE_DLY;
                        end
                    end
                end
                RX_PEND: begin
                    rx_dly_r <= rx_dly_r - 2'h1;
                    if (sync_done) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_r <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rx_data_r <= 8'h00;
        end else if (rx_done && !rx_full_r && !nocopy) begin
            rx_data_r <= rx_shift_r;
        end
    end

    // Status flags; hardware set beats software clear, except tx_empty_r: a TXDATA write blocks tx_load
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tx_empty_r <= 1'b1;
            tx_end_r <= 1'b1;
            rx_full_r <= 1'b0;
            ovr_r <= 1'b0;
            fer_r <= 1'b0;
            per_r <= 1'b0;
        end else begin
            tx_empty_r <= tx_load | (tx_empty_r & ~wr_txd);
            tx_end_r <= (tx_bit_end & tx_empty_r) | (tx_end_r & ~wr_txd);
            rx_full_r <= (rx_done & (nocopy | rx_full_r | (~done_fe & ~done_pe & ~err_any))) |
                (rx_full_r & ~dma_rxd_rd & ~(wr_st & ~wr_data[ST_RX_FULL]));
            ovr_r <= (rx_done & rx_full_r & ~nocopy) | (ovr_r & ~(wr_st & ~wr_data[ST_OVERRUN]));
            fer_r <= done_fe | (fer_r & ~(wr_st & ~wr_data[ST_FRAMING]));
            per_r <= done_pe | (per_r & ~(wr_st & ~wr_data[ST_PARITY]));
        end
    end

    // Read port, data one cycle after the strobe
    always_comb begin
        rd_nxt = '0;
        if (rd_en) begin
            if (hit(addr, OFS_CTRL)) begin
                rd_nxt[CTRL_W-1:0] = ctrl_r;
            end else if (hit(addr, OFS_BAUD)) begin
                rd_nxt[DIV_W-1:0] = baud_r;
            end else if (hit(addr, OFS_STATUS)) begin
                rd_nxt[ST_TX_EMPTY] = tx_empty_r;
                rd_nxt[ST_RX_FULL] = rx_full_r;
                rd_nxt[ST_OVERRUN] = ovr_r;
                rd_nxt[ST_FRAMING] = fer_r;
                rd_nxt[ST_PARITY] = per_r;
                rd_nxt[ST_TX_END] = tx_end_r;
            end else if (hit(addr, OFS_TXDATA)) begin
                rd_nxt[7:0] = tx_data_r;
            end else if (hit(addr, OFS_RXDATA)) begin
                rd_nxt[7:0] = rx_data_r;
            end
        end
    end

    // Disabled transmitter hands pin to port
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rd_data_r <= '0;
            txd_out_r <= 1'b1;
            txd_oe_r <= 1'b0;
            sck_oe_r <= 1'b0;
        end else begin
            rd_data_r <= rd_nxt;
            txd_out_r <= tx_en ? tx_shift_r[0] : port_data_bit;
            txd_oe_r <= tx_en | pin_function_ctrl;
            sck_oe_r <= sync & ~ext & (tx_en | rx_en);
        end
    end

    assign rd_data = rd_data_r;
    assign txd_out = txd_out_r;
    assign txd_oe = txd_oe_r;
    assign sck_out = sck_int_r;
    assign sck_oe = sck_oe_r;
    assign tx_empty_irq = tx_empty_r;
    assign rx_full_irq = rx_full_r;
    assign rx_error_irq = err_any;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_tx_load_empty: assert property (tx_load |=> tx_empty_r && tx_state_r == TX_SHIFT)
        else $error("load did not set buffer empty");
    chk_tx_overwrite: assert property (wr_txd |=> !tx_empty_r && tx_data_r == $past(wr_data[7:0]))
        else $error("transmit data write lost");
    chk_overrun_hold: assert property (rx_done && rx_full_r && !nocopy |=> ovr_r && rx_full_r && $stable(rx_data_r))
        else $error("overrun handled wrong");
    chk_error_copy: assert property (rx_done && !rx_full_r && (done_fe || done_pe) |=> !rx_full_r && !ovr_r && rx_data_r == $past(rx_shift_r))
        else $error("error frame not copied");
    chk_overrun_errors: assert property (rx_done && rx_full_r && done_fe && !wr_st |=> fer_r && ovr_r)
        else $error("combined errors not flagged");
    chk_break_framing: assert property (async_done && !rxd_s2 && !wr_st |=> fer_r)
        else $error("break not flagged");
    chk_port_fallback: assert property (!tx_en |=> txd_out == $past(port_data_bit) && txd_oe == $past(pin_function_ctrl))
        else $error("pin not handed to port");
    chk_tx_init: assert property ($fell(tx_en) |=> tx_state_r == TX_IDLE && tx_shift_r == '1)
        else $error("transmitter not initialised");
    chk_sync_err_block: assert property (sync && err_any |-> ##1 !(tx_state_r == TX_SHIFT && $past(tx_state_r) == TX_IDLE))
        else $error("transmit started with errors");
    chk_rx_disable_keep: assert property ($fell(rx_en) && !$past(rx_done) |-> $stable({ovr_r, fer_r, per_r}))
        else $error("receive disable touched errors");
    chk_late_disable: assert property (sync_done && !rx_en |=> rx_full_r && $stable(rx_data_r))
        else $error("late disable handled wrong");
    chk_sync_done_delay: assert property ($rose(rx_state_r == RX_PEND) |-> ##[1:2] sync_done)
        else $error("completion delay wrong");
    chk_dma_clear: assert property (dma_rxd_rd && !rx_done |=> !rx_full_r)
        else $error("dma read did not clear full");

    cov_async_frame: cover property (async_done && !done_fe && !done_pe);
    cov_overrun: cover property (rx_done && rx_full_r);
    cov_break: cover property (async_done && brk_r);
    cov_sync_tx: cover property (sync && tx_bit_end);

endmodule
`default_nettype wire

// ===== testbench/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(parameter int BIT_NS = 128, parameter int SCK_NS = 64) (
    // Link pins
    output logic rxd,
    output logic sck,
    input wire logic txd
);
    logic [7:0] rx_byte, tx_sync;
    int rx_count;
    initial begin
        rxd = 1'b1;
        sck = 1'b1;
        rx_byte = 8'h00;
        tx_sync = 8'h00;
        rx_count = 0;
    end
    // Clock idles high; data set on the fall, taken late in the high phase
    task automatic sync_byte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            sck = 1'b0;
            rxd = d[i];
            #(SCK_NS / 2);
            sck = 1'b1;
            #(SCK_NS / 2 - 1);
            tx_sync[i] = txd;
            #1;
        end
        rxd = 1'b1;
        #(4 * SCK_NS);
    endtask
    task automatic send_byte(input logic [7:0] d, input logic stop_lvl);
        rxd = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            rxd = d[i];
            #(BIT_NS);
        end
        rxd = stop_lvl;
        #(BIT_NS);
        rxd = 1'b1;
        #(2 * BIT_NS);
    endtask
    // Break: line held at a level
    task automatic set_line(input logic lvl);
        rxd = lvl;
    endtask
    // Mid-bit sampling of transmitted frames
    always begin
        @(negedge txd);
        #(BIT_NS * 3 / 2);
        for (int i = 0; i < 8; i++) begin
            rx_byte[i] = txd;
            #(BIT_NS);
        end
        rx_count++;
    end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import serial_pkg::*;
    logic sys_clk, rstn, wr_en, rd_en, dma_sel, port_data_bit, pin_function_ctrl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data, rv;
    logic tx_empty_irq, rx_full_irq, rx_error_irq, txd_out, txd_oe, sck_out, sck_oe;
    wire logic rxd_line;
    wire logic txd_line;
    wire logic sck_in;
    int fail_count, checked, n0;
    // Pull-up on the transmit line
    assign txd_line = txd_oe ? txd_out : 1'b1;
    serial_comm_unit u_dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .dma_sel(dma_sel), .rd_data(rd_data),
        .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
        .rxd_in(rxd_line), .txd_out(txd_out), .txd_oe(txd_oe), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .port_data_bit(port_data_bit),
        .pin_function_ctrl(pin_function_ctrl));
    serial_peer u_peer (.rxd(rxd_line), .sck(sck_in), .txd(txd_line));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic dma);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        dma_sel <= dma;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        dma_sel <= 1'b0;
        #1 rv = rd_data;
    endtask
    task automatic wait_peer();
        repeat (800) if (u_peer.rx_count == n0) @(posedge sys_clk);
    endtask
    task automatic t_reset();
        rd(OFS_STATUS, 1'b0);
        chk(rv, 32'h0000_0021);
        chk(32'(tx_empty_irq), 32'h1);
        rd(8'h14, 1'b0);
        chk(rv, 32'h0);
    endtask
    task automatic t_tx_overwrite();
        wr(OFS_CTRL, 32'h1);
        n0 = u_peer.rx_count;
        @(posedge sys_clk);
        addr <= OFS_TXDATA;
        wr_data <= 32'ha3;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_data <= 32'h3c;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        #1 chk(32'(tx_empty_irq), 32'h0);
        repeat (4) @(posedge sys_clk);
        #1 chk(32'(tx_empty_irq), 32'h1);
        wait_peer();
        chk(32'(u_peer.rx_byte), 32'h3c);
        repeat (400) @(posedge sys_clk);
        chk(32'(u_peer.rx_count), 32'(n0 + 1));
    endtask
    task automatic t_tx_abort();
        chk(32'(tx_empty_irq), 32'h1);
        wr(OFS_TXDATA, 32'h00);
        repeat (40) @(posedge sys_clk);
        wr(OFS_CTRL, 32'h0);
        repeat (2) @(posedge sys_clk);
        #1 chk({30'h0, txd_oe, txd_out}, 32'h3);
        // Break level through the port bit
        port_data_bit <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk({30'h0, txd_oe, txd_out}, 32'h2);
        port_data_bit <= 1'b1;
        repeat (250) @(posedge sys_clk);
        wr(OFS_CTRL, 32'h1);
        repeat (3) @(posedge sys_clk);
        #1 chk({30'h0, txd_oe, txd_out}, 32'h3);
        n0 = u_peer.rx_count;
        wr(OFS_TXDATA, 32'h96);
        wait_peer();
        chk(32'(u_peer.rx_byte), 32'h96);
    endtask
    task automatic t_rx_flags();
        wr(OFS_CTRL, 32'h2);
        u_peer.send_byte(8'h5a, 1'b1);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h02);
        u_peer.send_byte(8'h77, 1'b1);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h06);
        chk(32'(rx_error_irq), 32'h1);
        rd(OFS_RXDATA, 1'b0);
        chk(rv, 32'h5a);
        wr(OFS_CTRL, 32'h0);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h06);
        wr(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, 32'h2);
        u_peer.send_byte(8'h81, 1'b0);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h08);
        rd(OFS_RXDATA, 1'b0);
        chk(rv, 32'h81);
        wr(OFS_STATUS, 32'h0);
        u_peer.send_byte(8'h11, 1'b1);
        u_peer.send_byte(8'h22, 1'b0);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h0e);
        rd(OFS_RXDATA, 1'b1);
        chk(rv, 32'h11);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h0c);
        chk(32'(rx_full_irq), 32'h0);
        wr(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, 32'h12);
        u_peer.send_byte(8'h03, 1'b1);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h10);
        rd(OFS_RXDATA, 1'b0);
        chk(rv, 32'h03);
    endtask
    task automatic t_break();
        wr(OFS_STATUS, 32'h0);
        u_peer.set_line(1'b0);
        #2000;
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h08, 32'h08);
        wr(OFS_STATUS, 32'h0);
        #2000;
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h08, 32'h08);
        u_peer.set_line(1'b1);
    endtask
    task automatic t_sync_ext();
        repeat (250) @(posedge sys_clk);
        // Both enables together while the clock idles high
        wr(OFS_CTRL, 32'h0f);
        wr(OFS_STATUS, 32'h0);
        #1 chk({30'h0, sck_oe, sck_out}, 32'h1);
        u_peer.sync_byte(8'hc5);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h02);
        u_peer.sync_byte(8'h3a);
        rd(OFS_STATUS, 1'b0);
        chk(rv & 32'h1e, 32'h06);
        rd(OFS_RXDATA, 1'b0);
        chk(rv, 32'hc5);
        chk(32'(tx_empty_irq), 32'h1);
        wr(OFS_TXDATA, 32'h69);
        repeat (4) @(posedge sys_clk);
        #1 chk(32'(tx_empty_irq), 32'h0);
        wr(OFS_STATUS, 32'h0);
        repeat (5) @(posedge sys_clk);
        #1 chk(32'(tx_empty_irq), 32'h1);
        u_peer.sync_byte(8'h0f);
        chk(32'(u_peer.tx_sync), 32'h69);
        rd(OFS_RXDATA, 1'b1);
        chk(rv, 32'h0f);
        chk(32'(rx_full_irq), 32'h0);
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        rstn = 1'b0;
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        dma_sel = 1'b0;
        port_data_bit = 1'b1;
        pin_function_ctrl = 1'b1;
        fail_count = 0;
        checked = 0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_tx_overwrite();
        t_tx_abort();
        t_rx_flags();
        t_break();
        t_sync_ext();
        wrap_up();
    end
    initial begin
        #300000;
        fail_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
